// ### src/pcrc_pkg.sv
// Package of register map, field positions and sizes for the programmable CRC generator
package pcrc_pkg;

	// ************************************************************
	// Register indexes on the plain register port
	// ************************************************************
	localparam logic [2:0] OFS_CONTROL_ONE = 3'h0;
	localparam logic [2:0] OFS_CONTROL_TWO = 3'h1;
	localparam logic [2:0] OFS_POLY_LOW    = 3'h2;
	localparam logic [2:0] OFS_POLY_HIGH   = 3'h3;
	localparam logic [2:0] OFS_DATA_LOW    = 3'h4;
	localparam logic [2:0] OFS_DATA_HIGH   = 3'h5;
	localparam logic [2:0] OFS_RESULT_LOW  = 3'h6;
	localparam logic [2:0] OFS_RESULT_HIGH = 3'h7;

	// ************************************************************
	// Control one fields
	// ************************************************************
	localparam int BIT_MODULE_ENABLE = 15;
	localparam int BIT_IDLE_STOP     = 13;
	localparam int BIT_COUNT_LO      = 8;
	localparam int BIT_FULL          = 7;
	localparam int BIT_EMPTY         = 6;
	localparam int BIT_IRQ_SELECT    = 5;
	localparam int BIT_SHIFT_START   = 4;
	localparam int BIT_LSB_FIRST     = 3;

	// ************************************************************
	// Control two fields
	// ************************************************************
	localparam int BIT_WIDTH_LO = 8;
	localparam int BIT_POLY_LENGTH_SEL_LO  = 0;

	// ************************************************************
	// FIFO sizing
	// ************************************************************
	localparam logic [4:0] DEPTH_WIDE   = 5'h04;
	localparam logic [4:0] DEPTH_MID    = 5'h08;
	localparam logic [4:0] DEPTH_NARROW = 5'h10;
	localparam logic [4:0] WIDTH_WIDE_ABOVE  = 5'h0f;
	localparam logic [4:0] WIDTH_MID_FROM    = 5'h08;
	localparam int FIFO_SLOTS = 16;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [15:0] RST_REG16  = 16'h0000;
	localparam logic [31:0] RST_WORD32 = 32'h0000_0000;
	localparam logic [4:0]  RST_COUNT  = 5'h00;
	localparam logic [5:0]  RST_BITS   = 6'h00;

	// ************************************************************
	// Engine states
	// ************************************************************
	typedef enum logic [1:0]
	{
		PCRC_IDLE  = 2'b01,
		PCRC_SHIFT = 2'b10
	} pcrc_state_t;

endpackage : pcrc_pkg

// ### src/pcrc_top.sv
// Programmable CRC generator with input FIFO and shift engine
//
// Operation
// - Polynomial length from 5-bit field, to 32
// - Set term bit enables matching XOR tap
// - Zero-order term always applied; bit0 reads zero
// - Order-N term always present
// - Data width is width field plus one
// - FIFO depth 4, 8 or 16 by width
// - Byte writes; bits above width ignored
// - Count increments on MSB byte write
// - Start with words pops into shift buffer
// - Two bits per cycle until empty
// - Full at depth, empty at zero
// - Disable clears FIFO, count, data, result
// - Direction bit selects MSB or LSB first
// - Direction affects input only, result normal
// - Interrupt on count 1 to 0 or done
// - Software stop makes no interrupt
// - Hardware clears start on completion
// - Result pair writable for clear or resume
// - Idle stop halts module in Idle mode
// - Full and empty flags read-only, hardware kept
// - Width field at control two bits 12:8
// - Length field at control two bits 4:0
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pcrc_top
(
	input  wire logic        clk_in,     // 25 MHz clock
	input  wire logic        nrst_in,    // Async reset, active low
	input  wire logic        idle_in,    // Device in Idle mode
	input  wire logic [2:0]  addr_in,    // Register index
	input  wire logic [15:0] wdata_in,   // Write data
	input  wire logic [1:0]  wbe_in,     // Write byte enables
	input  wire logic        wr_in,      // Write strobe
	input  wire logic        rd_in,      // Read strobe
	output logic      [15:0] rdata_out,  // Read data, cycle after strobe
	output logic             irq_out     // Interrupt pulse
);

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic [4:0] fifo_depth(input logic [4:0] dw);
		if (dw > pcrc_pkg::WIDTH_WIDE_ABOVE)
			return pcrc_pkg::DEPTH_WIDE;
		else if (dw >= pcrc_pkg::WIDTH_MID_FROM)
			return pcrc_pkg::DEPTH_MID;
		else
			return pcrc_pkg::DEPTH_NARROW;
	endfunction : fifo_depth

	function automatic logic [31:0] crc_step(input logic [31:0] crc,
		input logic din, input logic [31:0] taps, input logic [4:0] poly_length_sel);
		logic        fb;
		logic [31:0] lenmask;
		logic [31:0] nxt;
		fb      = din ^ crc[poly_length_sel];
		lenmask = 32'hffff_ffff >> (5'h1f - poly_length_sel);
		nxt     = (crc << 1) & lenmask;
		if (fb)
			nxt = nxt ^ ((taps | 32'h0000_0001) & lenmask);
		return nxt;
	endfunction : crc_step

	function automatic logic [3:0] ptr_next(input logic [3:0] p, input logic [4:0] depth);
		return (p + 4'h1) & (depth[3:0] - 4'h1);
	endfunction : ptr_next

	// ************************************************************
	// Registers
	// ************************************************************
	logic                     enable_r;
	logic                     idle_stop_r;
	logic                     irq_sel_r;
	logic                     go_r;
	logic                     lsb_first_r;
	logic [4:0]               dw_r;
	logic [4:0]               poly_length_sel_r;
	logic [31:0]              taps_r;
	logic [31:0]              din_r;
	logic [31:0]              result_r;
	logic [31:0]              fifo_mem [pcrc_pkg::FIFO_SLOTS];
	logic [3:0]               wptr_r;
	logic [3:0]               rptr_r;
	logic [4:0]               cnt_r;
	logic [4:0]               cnt_nxt;
	logic [31:0]              buf_r;
	logic [5:0]               bits_r;
	pcrc_pkg::pcrc_state_t    state_r;

	// ************************************************************
	// Decode
	// ************************************************************
	logic        wr_con1;
	logic        wr_con2;
	logic        wr_dlo;
	logic        wr_dhi;
	logic        wr_rlo;
	logic        wr_rhi;
	logic [4:0]  depth;
	logic        full;
	logic        empty;
	logic        halt;
	logic [31:0] din_new;
	logic [31:0] wmask;
	logic        push;
	logic        pop;
	logic        last_step;
	logic        done;
	logic        sw_go_set;
	logic        stepping;
	logic        bit0;
	logic        bit1;
	logic [31:0] buf1;
	logic [31:0] buf2;
	logic [31:0] crc1;
	logic [31:0] crc2;

	assign wr_con1   = wr_in && addr_in == pcrc_pkg::OFS_CONTROL_ONE;
	assign wr_con2   = wr_in && addr_in == pcrc_pkg::OFS_CONTROL_TWO;
	assign wr_dlo    = wr_in && addr_in == pcrc_pkg::OFS_DATA_LOW;
	assign wr_dhi    = wr_in && addr_in == pcrc_pkg::OFS_DATA_HIGH;
	assign wr_rlo    = wr_in && addr_in == pcrc_pkg::OFS_RESULT_LOW;
	assign wr_rhi    = wr_in && addr_in == pcrc_pkg::OFS_RESULT_HIGH;
	assign depth     = fifo_depth(dw_r);
	assign full      = cnt_r == depth;
	assign empty     = cnt_r == pcrc_pkg::RST_COUNT;
	assign halt      = idle_stop_r && idle_in;
	assign wmask     = 32'hffff_ffff >> (5'h1f - dw_r);
	assign sw_go_set = wr_con1 && wbe_in[0];

	// Merge byte lanes of a data write into the staged word
	always_comb
	begin
		din_new = din_r;
		if (wr_dlo && wbe_in[0])
			din_new[7:0] = wdata_in[7:0];
		if (wr_dlo && wbe_in[1])
			din_new[15:8] = wdata_in[15:8];
		if (wr_dhi && wbe_in[0])
			din_new[23:16] = wdata_in[7:0];
		if (wr_dhi && wbe_in[1])
			din_new[31:24] = wdata_in[15:8];
	end

	// Push when the byte holding the top data bit is written
	always_comb
	begin
		unique case (dw_r[4:3])
			2'h0: push = wr_dlo && wbe_in[0];
			2'h1: push = wr_dlo && wbe_in[1];
			2'h2: push = wr_dhi && wbe_in[0];
			2'h3: push = wr_dhi && wbe_in[1];
		endcase
		push = push && enable_r && !full;
	end

	// ************************************************************
	// Shift datapath
	// ************************************************************
	assign bit0      = lsb_first_r ? buf_r[0] : buf_r[dw_r];
	assign buf1      = lsb_first_r ? (buf_r >> 1) : (buf_r << 1);
	assign bit1      = lsb_first_r ? buf1[0] : buf1[dw_r];
	assign buf2      = lsb_first_r ? (buf1 >> 1) : (buf1 << 1);
	assign crc1      = crc_step(result_r, bit0, taps_r, poly_length_sel_r);
	assign crc2      = crc_step(crc1, bit1, taps_r, poly_length_sel_r);
	assign stepping  = enable_r && !halt && go_r && state_r == pcrc_pkg::PCRC_SHIFT;
	assign last_step = stepping && bits_r <= 6'h02;
	assign pop       = enable_r && !halt && go_r && !empty
		&& (state_r == pcrc_pkg::PCRC_IDLE || last_step);
	assign done      = last_step && empty && !push;
	assign cnt_nxt   = cnt_r + {4'h0, push} - {4'h0, pop};

	// ************************************************************
	// Control registers
	// ************************************************************
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			enable_r    <= 1'b0;
			idle_stop_r <= 1'b0;
			irq_sel_r   <= 1'b0;
			lsb_first_r <= 1'b0;
			dw_r        <= pcrc_pkg::RST_COUNT;
			poly_length_sel_r      <= pcrc_pkg::RST_COUNT;
			taps_r      <= pcrc_pkg::RST_WORD32;
		end
		else
		begin
			if (wr_con1 && wbe_in[1])
			begin
				enable_r    <= wdata_in[pcrc_pkg::BIT_MODULE_ENABLE];
				idle_stop_r <= wdata_in[pcrc_pkg::BIT_IDLE_STOP];
			end
			if (wr_con1 && wbe_in[0])
			begin
				irq_sel_r   <= wdata_in[pcrc_pkg::BIT_IRQ_SELECT];
				lsb_first_r <= wdata_in[pcrc_pkg::BIT_LSB_FIRST];
			end
			if (wr_con2 && wbe_in[1])
				dw_r <= wdata_in[pcrc_pkg::BIT_WIDTH_LO +: 5];
			if (wr_con2 && wbe_in[0])
				poly_length_sel_r <= wdata_in[pcrc_pkg::BIT_POLY_LENGTH_SEL_LO +: 5];
			if (wr_in && addr_in == pcrc_pkg::OFS_POLY_LOW && wbe_in[0])
				taps_r[7:1] <= wdata_in[7:1];
			if (wr_in && addr_in == pcrc_pkg::OFS_POLY_LOW && wbe_in[1])
				taps_r[15:8] <= wdata_in[15:8];
			if (wr_in && addr_in == pcrc_pkg::OFS_POLY_HIGH && wbe_in[0])
				taps_r[23:16] <= wdata_in[7:0];
			if (wr_in && addr_in == pcrc_pkg::OFS_POLY_HIGH && wbe_in[1])
				taps_r[31:24] <= wdata_in[15:8];
		end
	end

	// Start bit: software set wins over hardware clear
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			go_r <= 1'b0;
		else if (wr_con1 && wbe_in[0])
			go_r <= wdata_in[pcrc_pkg::BIT_SHIFT_START];
		else if (done)
			go_r <= 1'b0;
	end

	// ************************************************************
	// FIFO and staged input word
	// ************************************************************
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			din_r  <= pcrc_pkg::RST_WORD32;
			wptr_r <= 4'h0;
			rptr_r <= 4'h0;
			cnt_r  <= pcrc_pkg::RST_COUNT;
		end
		else if (!enable_r)
		begin
			din_r  <= pcrc_pkg::RST_WORD32;
			wptr_r <= 4'h0;
			rptr_r <= 4'h0;
			cnt_r  <= pcrc_pkg::RST_COUNT;
		end
		else
		begin
			din_r <= din_new;
			if (push)
				wptr_r <= ptr_next(wptr_r, depth);
			if (pop)
				rptr_r <= ptr_next(rptr_r, depth);
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (push)
			fifo_mem[wptr_r] <= din_new & wmask;
	end

	// ************************************************************
	// Shift engine
	// ************************************************************
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state_r <= pcrc_pkg::PCRC_IDLE;
			buf_r   <= pcrc_pkg::RST_WORD32;
			bits_r  <= pcrc_pkg::RST_BITS;
		end
		else if (!enable_r)
		begin
			state_r <= pcrc_pkg::PCRC_IDLE;
			buf_r   <= pcrc_pkg::RST_WORD32;
			bits_r  <= pcrc_pkg::RST_BITS;
		end
		else if (pop)
		begin
			state_r <= pcrc_pkg::PCRC_SHIFT;
			buf_r   <= fifo_mem[rptr_r];
			bits_r  <= {1'b0, dw_r} + 6'h01;
		end
		else if (stepping)
		begin
			buf_r  <= buf2;
			bits_r <= last_step ? pcrc_pkg::RST_BITS : bits_r - 6'h02;
			if (last_step)
				state_r <= pcrc_pkg::PCRC_IDLE;
		end
		else if (!go_r)
			state_r <= pcrc_pkg::PCRC_IDLE;
	end

	// Result pair: engine update has priority over software write
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			result_r <= pcrc_pkg::RST_WORD32;
		else if (!enable_r)
			result_r <= pcrc_pkg::RST_WORD32;
		else if (stepping)
			result_r <= (bits_r >= 6'h02) ? crc2 : crc1;
		else
		begin
			if (wr_rlo && wbe_in[0])
				result_r[7:0] <= wdata_in[7:0];
			if (wr_rlo && wbe_in[1])
				result_r[15:8] <= wdata_in[15:8];
			if (wr_rhi && wbe_in[0])
				result_r[23:16] <= wdata_in[7:0];
			if (wr_rhi && wbe_in[1])
				result_r[31:24] <= wdata_in[15:8];
		end
	end

	// ************************************************************
	// Interrupt pulse
	// ************************************************************
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			irq_out <= 1'b0;
		else if (irq_sel_r)
			irq_out <= done && !sw_go_set;
		else
			irq_out <= enable_r && cnt_r == 5'h01 && cnt_nxt == 5'h00;
	end

	// ************************************************************
	// Read port
	// ************************************************************
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			rdata_out <= pcrc_pkg::RST_REG16;
		else if (!rd_in)
			rdata_out <= pcrc_pkg::RST_REG16;
		else
		begin
			unique case (addr_in)
				pcrc_pkg::OFS_CONTROL_ONE: rdata_out <= {enable_r, 1'b0, idle_stop_r, cnt_r,
					full, empty, irq_sel_r, go_r, lsb_first_r, 3'h0};
				pcrc_pkg::OFS_CONTROL_TWO: rdata_out <= {3'h0, dw_r, 3'h0, poly_length_sel_r};
				pcrc_pkg::OFS_POLY_LOW:    rdata_out <= {taps_r[15:1], 1'b0};
				pcrc_pkg::OFS_POLY_HIGH:   rdata_out <= taps_r[31:16];
				pcrc_pkg::OFS_DATA_LOW:    rdata_out <= din_r[15:0];
				pcrc_pkg::OFS_DATA_HIGH:   rdata_out <= din_r[31:16];
				pcrc_pkg::OFS_RESULT_LOW:  rdata_out <= result_r[15:0];
				pcrc_pkg::OFS_RESULT_HIGH: rdata_out <= result_r[31:16];
			endcase
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	a_count_limit: assert property (cnt_r <= depth)
		else $error("Word count above FIFO depth");
	a_disable_clear: assert property (!enable_r |=> cnt_r == 5'h00 && result_r == 32'h0)
		else $error("Disable did not clear FIFO or result");
	a_push_count: assert property (push && !pop && enable_r |=> cnt_r == $past(cnt_r) + 5'h01)
		else $error("Push did not increment count");
	a_pop_count: assert property (pop && !push |=> cnt_r == $past(cnt_r) - 5'h01)
		else $error("Pop did not decrement count");
	a_shift_two: assert property (stepping && bits_r > 6'h02 |=> bits_r == $past(bits_r) - 6'h02)
		else $error("Engine did not shift two bits");
	a_done_stop: assert property (done && !(wr_con1 && wbe_in[0]) |=> !go_r)
		else $error("Start bit not cleared on completion");
	a_irq_empty: assert property (!irq_sel_r && enable_r && cnt_r == 5'h01 && cnt_nxt == 5'h00
		|=> irq_out)
		else $error("No interrupt on count reaching zero");
	a_irq_cause: assert property (irq_out && $past(irq_sel_r) |-> $past(done))
		else $error("Completion interrupt without completion");
	a_idle_hold: assert property (halt && enable_r && !wr_rlo && !wr_rhi |=> $stable(result_r))
		else $error("Result changed while halted in Idle");
	a_full_flag: assert property ($rose(full) |-> $past(push))
		else $error("Full flag set without a push");

	c_fill_full:  cover property (enable_r && full);
	c_run_done:   cover property (irq_sel_r && done ##1 irq_out);
	c_lsb_word:   cover property (lsb_first_r && pop ##[1:16] done);
	c_idle_pause: cover property (stepping ##1 halt);

endmodule : pcrc_top

`default_nettype wire

// ### bench/programmable_crc_generator_bench.sv
// Self-checking bench for the programmable CRC generator
`timescale 1ns/1ps
`default_nettype none

module programmable_crc_generator_bench;

	// ************************************************************
	// Signals and design
	// ************************************************************
	logic        clk_in;
	logic        nrst_in;
	logic        idle_in;
	logic [2:0]  addr_in;
	logic [15:0] wdata_in;
	logic [1:0]  wbe_in;
	logic        wr_in;
	logic        rd_in;
	logic [15:0] rdata_out;
	logic        irq_out;
	int          fails = 0;
	int          total_checks = 0;
	int          irq_seen = 0;
	logic [31:0] rnd;

	pcrc_top i_pcrc_top
	(
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.idle_in   (idle_in),
		.addr_in   (addr_in),
		.wdata_in  (wdata_in),
		.wbe_in    (wbe_in),
		.wr_in     (wr_in),
		.rd_in     (rd_in),
		.rdata_out (rdata_out),
		.irq_out   (irq_out)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	always @(posedge clk_in)
	begin
		if (irq_out === 1'b1)
			irq_seen <= irq_seen + 1;
	end

	// ************************************************************
	// Expectation functions
	// ************************************************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
	endfunction : lfsr_next

	function automatic logic [4:0] depth_of(input logic [4:0] w);
		if (w > 5'h0f)
			return 5'h04;
		if (w >= 5'h08)
			return 5'h08;
		return 5'h10;
	endfunction : depth_of

	function automatic logic [31:0] len_mask(input logic [4:0] psel);
		return 32'((64'h1 << (int'(psel) + 1)) - 64'h1);
	endfunction : len_mask

	// Serial CRC over one word, non-reflected result
	function automatic logic [31:0] crc_word(input logic [31:0] res, input logic [31:0] word,
		input logic [4:0] wsel, input logic [4:0] psel, input logic [31:0] taps,
		input logic lsb);
		logic fb;
		for (int i = 0; i <= int'(wsel); i++)
		begin
			fb = (lsb ? word[i] : word[int'(wsel) - i]) ^ res[psel];
			res = ((res << 1) ^ (fb ? (taps | 32'h1) : 32'h0)) & len_mask(psel);
		end
		return res;
	endfunction : crc_word

	function automatic logic [15:0] c1(input logic en, input logic stp, input logic isel,
		input logic go, input logic lsb);
		return {en, 1'b0, stp, 5'h00, 2'b00, isel, go, lsb, 3'h0};
	endfunction : c1

	// ************************************************************
	// Bus and check tasks
	// ************************************************************
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	task automatic wr_reg(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
		addr_in  <= a;
		wdata_in <= d;
		wbe_in   <= be;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask : wr_reg

	task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		d = rdata_out;
		@(posedge clk_in);
	endtask : rd_reg

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd_reg(a, d);
		chk({16'h0, d}, {16'h0, exp});
	endtask : rd_chk

	task automatic push(input logic [31:0] w, input logic [4:0] wsel);
		if (wsel < 5'h08)
			wr_reg(pcrc_pkg::OFS_DATA_LOW, w[15:0], 2'b01);
		else
		begin
			wr_reg(pcrc_pkg::OFS_DATA_LOW, w[15:0], 2'b11);
			wr_reg(pcrc_pkg::OFS_DATA_HIGH, w[31:16], 2'b11);
		end
	endtask : push

	task automatic wait_done();
		logic [15:0] d;
		for (int k = 0; k < 200; k++)
		begin
			rd_reg(pcrc_pkg::OFS_CONTROL_ONE, d);
			if (d[pcrc_pkg::BIT_SHIFT_START] === 1'b0)
				return;
		end
		fails++;
		close_out();
	endtask : wait_done

	// One calculation; hold pauses it in Idle mode first
	task automatic run_calc(input logic [4:0] wsel, input logic [4:0] psel,
		input logic [31:0] taps, input logic [31:0] init, input logic lsb,
		input logic isel, input int nw, input logic hold);
		logic [31:0] exp;
		logic [15:0] lo;
		logic [15:0] hi;
		int          base;
		init = init & len_mask(psel);
		exp = init;
		idle_in <= 1'b1;
		wr_reg(pcrc_pkg::OFS_CONTROL_TWO, {3'h0, wsel, 3'h0, psel}, 2'b11);
		wr_reg(pcrc_pkg::OFS_POLY_LOW, taps[15:0], 2'b11);
		wr_reg(pcrc_pkg::OFS_POLY_HIGH, taps[31:16], 2'b11);
		wr_reg(pcrc_pkg::OFS_RESULT_LOW, init[15:0], 2'b11);
		wr_reg(pcrc_pkg::OFS_RESULT_HIGH, init[31:16], 2'b11);
		for (int i = 0; i < nw; i++)
		begin
			rnd = lfsr_next(rnd);
			push(rnd, wsel);
			exp = crc_word(exp, rnd, wsel, psel, taps, lsb);
		end
		base = irq_seen;
		wr_reg(pcrc_pkg::OFS_CONTROL_ONE, c1(1'b1, hold, isel, 1'b1, lsb), 2'b11);
		if (hold)
		begin
			repeat (40) @(posedge clk_in);
			chk(irq_seen - base, 0);
			rd_chk(pcrc_pkg::OFS_RESULT_LOW, init[15:0]);
			idle_in <= 1'b0;
		end
		wait_done();
		repeat (3) @(posedge clk_in);
		chk(irq_seen - base, 1);
		rd_chk(pcrc_pkg::OFS_CONTROL_ONE, c1(1'b1, hold, isel, 1'b0, lsb) | 16'h0040);
		rd_reg(pcrc_pkg::OFS_RESULT_LOW, lo);
		rd_reg(pcrc_pkg::OFS_RESULT_HIGH, hi);
		chk({hi, lo}, exp);
	endtask : run_calc

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		logic [4:0]  ws;
		logic [31:0] taps;
		int          base;
		nrst_in  = 1'b0;
		idle_in  = 1'b0;
		addr_in  = 3'h0;
		wdata_in = 16'h0000;
		wbe_in   = 2'b00;
		wr_in    = 1'b0;
		rd_in    = 1'b0;
		rnd      = 32'h0001_10b6;
		repeat (10) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		rd_chk(pcrc_pkg::OFS_CONTROL_ONE, 16'h0040);
		for (int a = 1; a < 8; a++)
			rd_chk(3'(a), 16'h0000);
		$display("test reset_values done");
		wr_reg(pcrc_pkg::OFS_CONTROL_ONE, c1(1'b1, 1'b0, 1'b0, 1'b0, 1'b0), 2'b11);
		wr_reg(pcrc_pkg::OFS_POLY_LOW, 16'hffff, 2'b11);
		rd_chk(pcrc_pkg::OFS_POLY_LOW, 16'hfffe);
		$display("test term_zero done");
		run_calc(5'h07, 5'h0f, 32'h0000_1020, 32'h0, 1'b0, 1'b1, 2, 1'b0);
		run_calc(5'h1f, 5'h1f, 32'h04c1_1db6, 32'hffff_ffff, 1'b1, 1'b0, 4, 1'b0);
		run_calc(5'h00, 5'h00, 32'h0, 32'h0, 1'b0, 1'b1, 16, 1'b0);
		run_calc(5'h0a, 5'h07, 32'h0000_0007, 32'h5a, 1'b1, 1'b1, 3, 1'b1);
		for (int i = 0; i < 10; i++)
		begin
			rnd = lfsr_next(rnd);
			ws = rnd[4:0];
			taps = lfsr_next(rnd);
			run_calc(ws, rnd[9:5], taps, lfsr_next(taps), rnd[10], rnd[11],
				1 + int'(rnd[13:12]), 1'b0);
		end
		$display("test calculations done");
		wr_reg(pcrc_pkg::OFS_CONTROL_ONE, 16'h8000, 2'b11);
		for (int k = 0; k < 3; k++)
		begin
			ws = (k == 0) ? 5'h1f : ((k == 1) ? 5'h0c : 5'h03);
			wr_reg(pcrc_pkg::OFS_CONTROL_TWO, {3'h0, ws, 8'h1f}, 2'b11);
			for (int i = 0; i <= int'(depth_of(ws)); i++)
				push(32'h5a5a_5a5a, ws);
			rd_chk(pcrc_pkg::OFS_CONTROL_ONE, 16'h8080 | {3'h0, depth_of(ws), 8'h00});
			wr_reg(pcrc_pkg::OFS_RESULT_LOW, 16'habcd, 2'b11);
			wr_reg(pcrc_pkg::OFS_CONTROL_ONE, 16'h0000, 2'b11);
			rd_chk(pcrc_pkg::OFS_CONTROL_ONE, 16'h0040);
			rd_chk(pcrc_pkg::OFS_RESULT_LOW, 16'h0000);
			rd_chk(pcrc_pkg::OFS_CONTROL_TWO, {3'h0, ws, 8'h1f});
			wr_reg(pcrc_pkg::OFS_CONTROL_ONE, 16'h8000, 2'b11);
		end
		$display("test fifo_depth done");
		wr_reg(pcrc_pkg::OFS_CONTROL_TWO, 16'h1f1f, 2'b11);
		for (int i = 0; i < 4; i++)
			push(lfsr_next(32'(i)), 5'h1f);
		base = irq_seen;
		wr_reg(pcrc_pkg::OFS_CONTROL_ONE, c1(1'b1, 1'b0, 1'b1, 1'b1, 1'b0), 2'b11);
		wr_reg(pcrc_pkg::OFS_CONTROL_ONE, c1(1'b1, 1'b0, 1'b1, 1'b0, 1'b0), 2'b11);
		repeat (100) @(posedge clk_in);
		chk(irq_seen - base, 0);
		$display("test software_stop done");
		close_out();
	end

endmodule : programmable_crc_generator_bench

`default_nettype wire
